// [core/srx_serial_rx.v]
// serial receive unit: apb registers, base clock, async and clocked receive,
// receive-full and overrun handling, serial clock and transmit pin switching
// assumes RXD and SCK_I come from pins outside the CLK domain
`include "srx_regs.vh"

module srx_serial_rx (
	input  wire        CLK,
	input  wire        RESETN,
	input  wire        PSEL,
	input  wire        PENABLE,
	input  wire        PWRITE,
	input  wire [7:0]  PADDR,
	input  wire [31:0] PWDATA,
	output reg         PREADY,
	output reg  [31:0] PRDATA,
	output reg         PSLVERR,
	input  wire        RXD,
	input  wire        SCK_I,
	output reg         SCK_O,
	output reg         SCK_OE,
	output reg         TXD_O,
	output reg         TXD_OE
);
	reg  [1:0]               rst_sync_q;
	wire                     rst_n;

	reg                      rxd_meta_q;
	reg                      rxd_q;
	reg                      sck_meta_q;
	reg                      sck_in_q;
	reg                      sck_in_prev_q;

	reg  [`SRX_CTL_W-1:0]    ctrl_q;
	reg  [`SRX_BAUD_W-1:0]   baud_div_q;
	reg  [`SRX_PT_W-1:0]     port_q;
	reg                      full_q;
	reg                      ovr_q;
	reg                      frm_q;
	reg  [`SRX_DATA_W-1:0]   rx_buffer_q;

	reg  [`SRX_BAUD_W-1:0]   baud_cnt_q;
	reg  [`SRX_PH_W-1:0]     sck_ph_q;
	reg                      sck_gen_q;
	reg  [`SRX_DATA_W-1:0]   sync_sh_q;
	reg  [2:0]               sync_cnt_q;
	reg                      sync_done_q;
	reg  [`SRX_DATA_W-1:0]   sync_data_q;
	reg                      was_clk_out_q;
	reg                      was_tx_sync_q;

	wire                     tx_on_bit;
	wire                     rx_on_bit;
	wire                     clk_src_lo;
	wire                     clk_src_hi;
	wire                     sync_mode;
	wire                     base_tick;
	wire                     async_done;
	wire [`SRX_DATA_W-1:0]   async_data;
	wire                     async_ferr;
	wire                     sck_rise_int;
	wire                     sck_rise_ext;
	wire                     sync_edge;
	wire                     frame_done;
	wire [`SRX_DATA_W-1:0]   frame_data;
	wire                     clk_out_role;
	wire                     sck_port_role;
	wire                     setup;
	wire                     access;
	wire                     wr;
	wire                     rd_buf;
	reg                      hit;
	reg  [31:0]              rdata;

	assign tx_on_bit  = ctrl_q[`SRX_CTL_TX_ON];
	assign rx_on_bit  = ctrl_q[`SRX_CTL_RX_ON];
	assign clk_src_lo = ctrl_q[`SRX_CTL_CLK_LO];
	assign clk_src_hi = ctrl_q[`SRX_CTL_CLK_HI];
	assign sync_mode  = ctrl_q[`SRX_CTL_SYNC];

	// reset released through two flops, asserted at once
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN)
			rst_sync_q <= 2'b00;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n = rst_sync_q[1];

	// pin synchronisers; the first flop is never looked at, the sck edge also uses a third
	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			rxd_meta_q    <= 1'b1;
			rxd_q         <= 1'b1;
			sck_meta_q    <= 1'b1;
			sck_in_q      <= 1'b1;
			sck_in_prev_q <= 1'b1;
		end else begin
			rxd_meta_q    <= RXD;
			rxd_q         <= rxd_meta_q;
			sck_meta_q    <= SCK_I;
			sck_in_q      <= sck_meta_q;
			sck_in_prev_q <= sck_in_q;
		end
	end

	// apb handshake: one wait-free access phase after each setup
	assign setup  = PSEL & ~PENABLE;
	assign access = PSEL & PENABLE & PREADY;
	assign wr     = access & PWRITE;
	assign rd_buf = access & ~PWRITE & (PADDR == `SRX_OFF_RXBUF);

	always @* begin
		hit   = 1'b1;
		rdata = 32'h0000_0000;
		case (PADDR)
		`SRX_OFF_CTRL:  rdata[`SRX_CTL_W-1:0]   = ctrl_q;
		`SRX_OFF_BAUD:  rdata[`SRX_BAUD_W-1:0]  = baud_div_q;
		`SRX_OFF_STAT: begin
			rdata[`SRX_ST_FULL] = full_q;
			rdata[`SRX_ST_OVR]  = ovr_q;
			rdata[`SRX_ST_FRM]  = frm_q;
		end
		`SRX_OFF_RXBUF: rdata[`SRX_DATA_W-1:0]  = rx_buffer_q;
		`SRX_OFF_PORT:  rdata[`SRX_PT_W-1:0]    = port_q;
		default:        hit = 1'b0;
		endcase
	end

	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			PREADY  <= 1'b0;
			PRDATA  <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end else begin
			PREADY  <= setup;
			PSLVERR <= setup & ~hit;
			// data latched in setup; a frame landing in that cycle is seen next read
			if (setup && !PWRITE)
				PRDATA <= rdata;
			else if (access)
				PRDATA <= 32'h0000_0000;
		end
	end

	// software registers
	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q     <= `SRX_CTL_RST;
			baud_div_q <= `SRX_BAUD_RST;
			port_q     <= `SRX_PT_RST;
		end else if (wr) begin
			// one write may change every control bit together
			if (PADDR == `SRX_OFF_CTRL)
				ctrl_q <= PWDATA[`SRX_CTL_W-1:0];
			if (PADDR == `SRX_OFF_BAUD)
				baud_div_q <= PWDATA[`SRX_BAUD_W-1:0];
			if (PADDR == `SRX_OFF_PORT)
				port_q <= PWDATA[`SRX_PT_W-1:0];
		end
	end

	// base clock at 16x bit rate from the divisor
	assign base_tick = (rx_on_bit | tx_on_bit) && (baud_cnt_q == baud_div_q);

	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n)
			baud_cnt_q <= {`SRX_BAUD_W{1'b0}};
		else if (!(rx_on_bit | tx_on_bit) || base_tick)
			baud_cnt_q <= {`SRX_BAUD_W{1'b0}};
		else
			baud_cnt_q <= baud_cnt_q + 16'h0001;
	end

	srx_async_rx u_async (
		.clk         (CLK),
		.rst_n       (rst_n),
		.en          (rx_on_bit & ~sync_mode),
		.tick        (base_tick),
		.rxd         (rxd_q),
		.done_q      (async_done),
		.data_q      (async_data),
		.frame_err_q (async_ferr)
	);

	// internal serial clock: one bit per 16 base ticks, idles high
	assign clk_out_role = sync_mode & ~clk_src_hi;
	assign sck_rise_int = base_tick && !sck_gen_q && (sck_ph_q[2:0] == `SRX_PH_HALF);
	assign sck_rise_ext = sck_in_q & ~sck_in_prev_q;
	assign sync_edge    = sync_mode & rx_on_bit & (clk_src_hi ? sck_rise_ext : sck_rise_int);

	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			sck_ph_q  <= {`SRX_PH_W{1'b0}};
			sck_gen_q <= 1'b1;
		end else if (!clk_out_role || !(rx_on_bit | tx_on_bit)) begin
			// clock stops high when both directions are off
			sck_ph_q  <= {`SRX_PH_W{1'b0}};
			sck_gen_q <= 1'b1;
		end else if (base_tick) begin
			sck_ph_q <= sck_ph_q + 4'h1;
			if (sck_ph_q[2:0] == `SRX_PH_HALF)
				sck_gen_q <= ~sck_gen_q;
		end
	end

	// clocked receive: bits taken on rising serial clock, lsb first
	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			sync_sh_q   <= {`SRX_DATA_W{1'b0}};
			sync_cnt_q  <= 3'h0;
			sync_done_q <= 1'b0;
			sync_data_q <= {`SRX_DATA_W{1'b0}};
		end else begin
			sync_done_q <= 1'b0;
			if (!(sync_mode && rx_on_bit)) begin
				sync_cnt_q <= 3'h0;
			end else if (sync_edge) begin
				sync_sh_q  <= {rxd_q, sync_sh_q[`SRX_DATA_W-1:1]};
				sync_cnt_q <= sync_cnt_q + 3'h1;
				if (sync_cnt_q == `SRX_LAST_BIT) begin
					sync_done_q <= 1'b1;
					sync_data_q <= {rxd_q, sync_sh_q[`SRX_DATA_W-1:1]};
				end
			end
		end
	end

	assign frame_done = async_done | sync_done_q;
	assign frame_data = sync_done_q ? sync_data_q : async_data;

	// receive buffer and flags; a hardware set beats a clear in the same cycle
	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			full_q      <= 1'b0;
			ovr_q       <= 1'b0;
			frm_q       <= 1'b0;
			rx_buffer_q <= {`SRX_DATA_W{1'b0}};
		end else begin
			if (frame_done && full_q) begin
				// old data kept, new frame dropped
				ovr_q <= 1'b1;
			end else if (frame_done) begin
				rx_buffer_q <= frame_data;
				full_q      <= 1'b1;
				frm_q       <= async_done & async_ferr;
			end
			if (rd_buf && !(frame_done && !full_q))
				full_q <= 1'b0;
			if (wr && PADDR == `SRX_OFF_STAT) begin
				if (PWDATA[`SRX_ST_OVR] && !(frame_done && full_q))
					ovr_q <= 1'b0;
				if (PWDATA[`SRX_ST_FRM] && !(frame_done && !full_q))
					frm_q <= 1'b0;
			end
		end
	end

	// pin roles
	assign sck_port_role = ~sync_mode & ~clk_src_hi & ~clk_src_lo;

	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			was_clk_out_q <= 1'b0;
			was_tx_sync_q <= 1'b0;
			SCK_O         <= 1'b0;
			SCK_OE        <= 1'b0;
			TXD_O         <= 1'b0;
			TXD_OE        <= 1'b0;
		end else begin
			was_clk_out_q <= clk_out_role;
			was_tx_sync_q <= sync_mode & tx_on_bit;
			if (was_clk_out_q && sck_port_role) begin
				// one-cycle low as the clock output hands over to the port
				SCK_O  <= 1'b0;
				SCK_OE <= 1'b1;
			end else if (clk_out_role) begin
				SCK_O  <= sck_gen_q;
				SCK_OE <= 1'b1;
			end else if (sck_port_role) begin
				SCK_O  <= port_q[`SRX_PT_SCK_DATA];
				SCK_OE <= port_q[`SRX_PT_SCK_DIR];
			end else begin
				SCK_O  <= 1'b0;
				SCK_OE <= 1'b0;
			end
			if (was_tx_sync_q && !tx_on_bit) begin
				TXD_O  <= 1'b1;
				TXD_OE <= 1'b1;
			end else if (tx_on_bit) begin
				// no transmit path here; serial line held at mark
				TXD_O  <= 1'b1;
				TXD_OE <= 1'b1;
			end else begin
				TXD_O  <= port_q[`SRX_PT_TXD_DATA];
				TXD_OE <= port_q[`SRX_PT_TXD_DIR];
			end
		end
	end
endmodule // srx_serial_rx

// [common/srx_regs.vh]
// register map, field positions, reset values and timing counts of the serial receive block
// assumes a 32-bit APB slave with byte addresses decoded on the low 8 address bits
`ifndef SRX_REGS_VH
`define SRX_REGS_VH

// register byte offsets
`define SRX_OFF_CTRL      8'h00
`define SRX_OFF_BAUD      8'h04
`define SRX_OFF_STAT      8'h08
`define SRX_OFF_RXBUF     8'h0c
`define SRX_OFF_PORT      8'h10

// control register fields
`define SRX_CTL_TX_ON     0
`define SRX_CTL_RX_ON     1
`define SRX_CTL_CLK_LO    2
`define SRX_CTL_CLK_HI    3
`define SRX_CTL_SYNC      4
`define SRX_CTL_W         5
`define SRX_CTL_RST       5'h00

// status register fields
`define SRX_ST_FULL       0
`define SRX_ST_OVR        1
`define SRX_ST_FRM        2

// general port register fields
`define SRX_PT_SCK_DATA   0
`define SRX_PT_SCK_DIR    1
`define SRX_PT_TXD_DATA   2
`define SRX_PT_TXD_DIR    3
`define SRX_PT_W          4
`define SRX_PT_RST        4'h0

// base clock divisor: one base tick every (value + 1) system clocks
`define SRX_BAUD_W        16
`define SRX_BAUD_RST      16'h0040

// base clock runs at 16 times the bit rate
`define SRX_PH_W          4
`define SRX_PH_SAMPLE     4'h7
`define SRX_PH_LAST       4'hf
`define SRX_PH_HALF       3'h7
`define SRX_LAST_BIT      3'h7
`define SRX_DATA_W        8

`endif

// [core/srx_async_rx.v]
// asynchronous frame receiver: start bit, 8 data bits lsb first, one stop bit
// assumes rxd is already synchronised and tick is a one-cycle base clock pulse
`include "srx_regs.vh"

module srx_async_rx (
	input  wire                   clk,
	input  wire                   rst_n,
	input  wire                   en,
	input  wire                   tick,
	input  wire                   rxd,
	output reg                    done_q,
	output reg  [`SRX_DATA_W-1:0] data_q,
	output reg                    frame_err_q
);
	localparam IDLE  = 2'b00;
	localparam START = 2'b01;
	localparam DATA  = 2'b10;
	localparam STOP  = 2'b11;

	reg [1:0]             state_q;
	reg [`SRX_PH_W-1:0]   ph_q;
	reg [2:0]             cnt_q;
	reg                   prev_q;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q     <= IDLE;
			ph_q        <= {`SRX_PH_W{1'b0}};
			cnt_q       <= 3'h0;
			prev_q      <= 1'b1;
			done_q      <= 1'b0;
			data_q      <= {`SRX_DATA_W{1'b0}};
			frame_err_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (!en) begin
				state_q <= IDLE;
				prev_q  <= 1'b1;
			end else if (tick) begin
				// line sampled only on the base clock
				prev_q <= rxd;
				ph_q   <= ph_q + 4'h1;
				case (state_q)
				IDLE: begin
					if (prev_q && !rxd) begin
						ph_q    <= {`SRX_PH_W{1'b0}};
						state_q <= START;
					end
				end
				START: begin
					// a low that is gone by mid-bit was noise
					if (ph_q == `SRX_PH_SAMPLE && rxd)
						state_q <= IDLE;
					else if (ph_q == `SRX_PH_LAST) begin
						state_q <= DATA;
						cnt_q   <= 3'h0;
					end
				end
				DATA: begin
					if (ph_q == `SRX_PH_SAMPLE)
						data_q <= {rxd, data_q[`SRX_DATA_W-1:1]};
					if (ph_q == `SRX_PH_LAST) begin
						if (cnt_q == `SRX_LAST_BIT)
							state_q <= STOP;
						else
							cnt_q <= cnt_q + 3'h1;
					end
				end
				STOP: begin
					if (ph_q == `SRX_PH_SAMPLE) begin
						done_q      <= 1'b1;
						frame_err_q <= ~rxd;
						state_q     <= IDLE;
					end
				end
				default: state_q <= IDLE;
				endcase
			end
		end
	end
endmodule // srx_async_rx

// [bench/srx_serial_rx_monitor.sv]
// apb timing and receive-flag assertions for the serial receive unit
// assumes it is bound to srx_serial_rx and sees only its ports
module srx_serial_rx_monitor (
	input wire logic        CLK,
	input wire logic        RESETN,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [7:0]  PADDR,
	input wire logic        PREADY,
	input wire logic [31:0] PRDATA,
	input wire logic        PSLVERR
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);
	wire stp = PSEL && !PENABLE;
	wire bad = PADDR > 8'h10 || PADDR[1:0] != 2'b00;

	a_ready_after_setup: assert property (stp |=> PREADY) else $error("no ready after setup");
	a_ready_one_cycle: assert property (PREADY |=> !PREADY) else $error("ready held");
	a_err_with_ready: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
		else $error("error without ready");
	a_idle_data_zero: assert property (!PREADY |-> PRDATA == 32'h0) else $error("stale data");
	a_unmapped_err: assert property (stp && bad |=> PSLVERR) else $error("no error");
	a_mapped_ok: assert property (stp && !bad |=> !PSLVERR) else $error("false error");
	a_rxbuf_narrow: assert property (stp && !PWRITE && PADDR == 8'h0c |=> PRDATA[31:8] == 24'h0)
		else $error("buffer upper bits set");
	a_read_clears_full: assert property (PREADY && !PWRITE && PADDR == 8'h0c ##1
		stp && !PWRITE && PADDR == 8'h08 |=> !PRDATA[0]) else $error("full kept");

	cover property (PSLVERR);
	cover property (PREADY && !PWRITE && PADDR == 8'h0c);
	cover property (PREADY && PWRITE && PADDR == 8'h00);
endmodule // srx_serial_rx_monitor

bind srx_serial_rx srx_serial_rx_monitor u_srx_serial_rx_monitor (.CLK(CLK), .RESETN(RESETN),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PREADY(PREADY),
	.PRDATA(PRDATA), .PSLVERR(PSLVERR));

// [bench/srx_station.sv]
// remote serial station: sends async and clocked frames, lsb first
// assumes clk is the receiver's system clock; every line change is counted on it
module srx_station (
	input wire logic clk,
	output logic     rxd,
	output logic     sck
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		rxd = 1'b1;
		sck = 1'b1;
	end
	task automatic send_async(input logic [7:0] b, input logic stop, input int bit_clks);
		logic [9:0] f;
		f = {stop, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (bit_clks) @(posedge clk);
		end
		// a low stop would leave the line in break: back to mark
		if (!stop) begin
			rxd <= 1'b1;
			repeat (bit_clks) @(posedge clk);
		end
	endtask
	// clock stands high outside frames; data moves on the falling edge
	// half period of 5 system clocks gives the 80 ns link clock
	task automatic send_sync(input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			sck <= 1'b0;
			rxd <= b[i];
			repeat (5) @(posedge clk);
			sck <= 1'b1;
			repeat (5) @(posedge clk);
		end
		rxd <= ~b[7];
	endtask
endmodule // srx_station

// [bench/srx_serial_rx_tb.sv]
// self-checking bench for the serial receive unit
// assumes design, monitor and remote station model are compiled first
module srx_serial_rx_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        CLK = 0, RESETN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
	logic [7:0]  PADDR = 0;
	logic [31:0] PWDATA = 0, PRDATA, r;
	logic        PREADY, PSLVERR, RXD, SCK_I, SCK_O, SCK_OE, TXD_O, TXD_OE, e;
	logic [3:0]  pins;
	int          failures = 0, total_checks = 0, lows;
	srx_serial_rx u_srx_serial_rx (.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA),
		.PSLVERR(PSLVERR), .RXD(RXD), .SCK_I(SCK_I), .SCK_O(SCK_O), .SCK_OE(SCK_OE),
		.TXD_O(TXD_O), .TXD_OE(TXD_OE));
	srx_station u_srx_station (.clk(CLK), .rxd(RXD), .sck(SCK_I));
	initial forever #4 CLK = ~CLK;
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		total_checks++;
		if (g !== x) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, x, g);
		end
	endtask
	// keep leaves psel up so the next setup follows at once
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic keep, output logic [31:0] q, output logic err);
		int n;
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		n = 0;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do begin
			@(posedge CLK);
			n++;
		end while (PREADY !== 1'b1 && n < 20);
		if (n >= 20) failures++;
		q = PRDATA;
		err = PSLVERR;
		PENABLE <= 1'b0;
		if (!keep) begin
			PSEL <= 1'b0;
			@(posedge CLK);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 1'b0, r, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input string n);
		apb(1'b0, a, 32'h0, 1'b0, r, e);
		chk(n, x, r);
	endtask
	// write control, then watch the pins for five cycles
	task automatic sw(input logic [7:0] c);
		apb(1'b1, 8'h00, {24'h0, c}, 1'b1, r, e);
		PSEL <= 1'b0;
		lows = 0;
		repeat (5) begin
			@(negedge CLK);
			if (SCK_OE === 1'b1 && SCK_O === 1'b0) begin
				lows++;
				chk("glitch", 4'b0111, {SCK_O, SCK_OE, TXD_O, TXD_OE});
			end
		end
		pins = {SCK_O, SCK_OE, TXD_O, TXD_OE};
		@(posedge CLK);
	endtask
	task automatic t_reset();
		rd(8'h00, 32'h0, "ctrl");
		rd(8'h04, 32'h40, "baud");
		rd(8'h10, 32'h0, "port");
		chk("oe", 32'h0, {SCK_OE, TXD_OE});
		wr(8'h08, 32'h1);
		rd(8'h08, 32'h0, "stat");
		apb(1'b0, 8'h20, 32'h0, 1'b0, r, e);
		chk("unmapped", 32'h1, {r[30:0], e});
		$display("test reset done");
	endtask
	task automatic t_async();
		wr(8'h04, 32'h0);
		wr(8'h00, 32'h2);
		u_srx_station.send_async(8'ha5, 1'b1, 16);
		rd(8'h08, 32'h1, "full");
		apb(1'b0, 8'h0c, 32'h0, 1'b1, r, e);
		chk("data", 32'ha5, r);
		rd(8'h08, 32'h0, "full cleared");
		u_srx_station.send_async(8'h3c, 1'b1, 16);
		u_srx_station.send_async(8'h81, 1'b1, 16);
		rd(8'h08, 32'h3, "overrun");
		rd(8'h0c, 32'h3c, "kept");
		wr(8'h08, 32'h2);
		u_srx_station.send_async(8'h55, 1'b0, 16);
		rd(8'h08, 32'h5, "framing");
		rd(8'h0c, 32'h55, "framed data");
		wr(8'h08, 32'h4);
		wr(8'h04, 32'h1);
		u_srx_station.send_async(8'h96, 1'b1, 32);
		rd(8'h0c, 32'h96, "slow data");
		$display("test async done");
	endtask
	task automatic t_sync();
		wr(8'h00, 32'h1a);
		u_srx_station.send_sync(8'hc3);
		repeat (8) @(posedge CLK);
		rd(8'h0c, 32'hc3, "sync data");
		wr(8'h00, 32'h0);
		$display("test sync done");
	endtask
	task automatic t_pins();
		wr(8'h10, 32'h0b);
		sw(8'h11);
		chk("serial", 4'b1111, pins);
		// low half of the internal clock: 8 base ticks at 2 CLK each
		lows = 0;
		repeat (40) begin
			@(negedge CLK);
			if (SCK_O === 1'b0)
				lows++;
		end
		chk("clock low half", 32'h10, lows);
		// switch early in a high half so only the handover glitch is low
		@(posedge SCK_O);
		sw(8'h00);
		chk("lows", 1, lows);
		chk("port", 4'b1101, pins);
		sw(8'h11);
		sw(8'h18);
		chk("stopped", 3'b001, pins[2:0]);
		sw(8'h08);
		sw(8'h00);
		chk("quiet", 4'b1101, pins);
		chk("no glitch", 32'h0, lows);
		$display("test pins done");
	endtask
	task automatic conclude();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#100us;
		failures++;
		conclude();
	end
	initial begin
		repeat (4) @(posedge CLK);
		RESETN <= 1'b1;
		repeat (3) @(posedge CLK);
		t_reset();
		t_async();
		t_sync();
		t_pins();
		conclude();
	end
endmodule // srx_serial_rx_tb
